// ### design/pbm_top.sv
`timescale 1ns/1ps
module pbm_top #(
	parameter logic [31:0] DEB_CYC     = pbm_pkg::DEB_MS * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] LS1_CYC     = pbm_pkg::LS1_MS * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] LS2_CYC     = pbm_pkg::LS2_MS * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] HOLD_CYC    = pbm_pkg::HOLD_MS * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] CUE_CYC_12K = pbm_pkg::CUE_MS_12K * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] CUE_CYC_8K  = pbm_pkg::CUE_MS_8K * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] CUE_CYC_6K4 = pbm_pkg::CUE_MS_6K4 * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] CUE_CYC_5K3 = pbm_pkg::CUE_MS_5K3 * pbm_pkg::CYC_PER_MS,
	parameter logic [31:0] CUE_CYC_4K  = pbm_pkg::CUE_MS_4K * pbm_pkg::CYC_PER_MS
) (
	// clock and reset
	input  wire logic                     REF_CLK,
	input  wire logic                     SRST,
	// push buttons, active low
	input  wire pbm_pkg::pbm_btn_t        BUTTON_N,
	// memory manager status
	input  wire logic                     STORED_EMPTY,
	input  wire logic [pbm_pkg::ROW_W-1:0] STORED_FREE_ROW,
	input  wire logic [pbm_pkg::ROW_W-1:0] STORED_LAST_ROW,
	input  wire logic [pbm_pkg::ROW_W-1:0] NEXT_START_ROW,
	input  wire logic [pbm_pkg::ROW_W-1:0] FIRST_START_ROW,
	input  wire logic                     PTR_IS_LAST,
	input  wire logic [pbm_pkg::ROW_W-1:0] WRITE_ROW,
	input  wire logic                     MEM_FULL,
	input  wire logic                     MSG_END,
	input  wire logic                     CMA_BAD,
	input  wire logic [3:0]               CUE_PROG,
	input  wire logic [2:0]               RATE_SEL,
	// indication and engine control
	output logic                          LED,
	output logic                          REC_ON,
	output logic                          PLAY_ON,
	output logic                          CUE_PLAY,
	output logic [1:0]                    CUE_SEL,
	output logic                          CUE_MODE,
	output logic                          CUE_CLEAR,
	output logic [pbm_pkg::ROW_W-1:0]     REC_PTR,
	output logic [pbm_pkg::ROW_W-1:0]     PLAY_PTR
);
	import pbm_pkg::*;

	pbm_st_t    q;
	pbm_st_t    d;
	logic [3:0] pin_v;
	logic [3:0] lvl_v;
	logic [3:0] fall_v;
	pbm_btn_t   lvl;
	pbm_btn_t   fall;
	logic [31:0] cue_len;

	// ==========================================
	// button filters
	assign pin_v = BUTTON_N;
	generate
		for (genvar i = 0; i < 4; i++) begin : g_deb
			pbm_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
				.clk    (REF_CLK),
				.srst   (SRST),
				.pin_n  (pin_v[i]),
				.level_q(lvl_v[i]),
				.fall_q (fall_v[i])
			);
		end
	endgenerate
	assign lvl  = lvl_v;
	assign fall = fall_v;

	// ==========================================
	// helpers
	function automatic logic [31:0] cue_len_f(input logic [2:0] rate);
		case (rate)
			RATE_12K: cue_len_f = CUE_CYC_12K;
			RATE_8K:  cue_len_f = CUE_CYC_8K;
			RATE_6K4: cue_len_f = CUE_CYC_6K4;
			RATE_5K3: cue_len_f = CUE_CYC_5K3;
			default:  cue_len_f = CUE_CYC_4K;
		endcase
	endfunction

	// start n flashes; a programmed cue sets the period and plays alongside
	function automatic pbm_st_t blink_f(input pbm_st_t st, input logic [3:0] n, input logic [1:0] idx,
		input logic prog, input logic [31:0] clen, input pbm_state_t ret);
		pbm_st_t r;
		r          = st;
		r.state    = S_BLINK;
		r.ret      = ret;
		r.blinks   = n;
		r.tmr      = '0;
		r.led      = 1'b1;
		r.rec_on   = 1'b0;
		r.play_on  = 1'b0;
		r.cue_play = prog;
		r.cue_sel  = idx;
		r.per      = prog ? clen : ((idx == CUE_ONE) ? LS1_CYC : LS2_CYC);
		blink_f    = r;
	endfunction

	function automatic logic [ROW_W-1:0] cue_row_f(input logic [1:0] idx);
		cue_row_f = ROW_W'(idx) * ROW_W'(CUE_ROWS);
	endfunction

	assign cue_len = cue_len_f(RATE_SEL);

	// ==========================================
	// control state machine
	always_comb begin
		d           = q;
		d.cue_clear = 1'b0;
		d.init      = 1'b0;
		// skip hold timer; parks past HOLD_CYC once used so one hold toggles once
		if (lvl.skip) begin
			d.hold = '0;
		end else if (q.hold < HOLD_CYC) begin
			d.hold = q.hold + 32'h1;
		end
		if (q.init) begin
			d.rec_ptr  = STORED_EMPTY ? '0 : STORED_FREE_ROW;
			d.play_ptr = STORED_EMPTY ? '0 : STORED_LAST_ROW;
		end
		case (q.state)
			S_IDLE: begin
				d.led      = 1'b0;
				d.rec_on   = 1'b0;
				d.play_on  = 1'b0;
				d.cue_play = 1'b0;
				if (!q.cue_mode && CMA_BAD && (fall != '0)) begin
					d = blink_f(d, CORRUPT_BLINKS, CUE_ONE, 1'b0, cue_len, S_IDLE);
				end else if (q.hold == HOLD_CYC && !lvl.capture) begin
					d.hold = HOLD_CYC + 32'h1;
					if (q.cue_mode) begin
						d.cue_mode = 1'b0;
						d.play_ptr = q.save_play;
						d.rec_ptr  = q.save_rec;
						d = blink_f(d, WRAP_BLINKS, CUE_TWO, CUE_PROG[1], cue_len, S_IDLE);
					end else begin
						d.cue_mode  = 1'b1;
						d.cue_idx   = CUE_ONE;
						d.save_play = q.play_ptr;
						d.save_rec  = q.rec_ptr;
						d.play_ptr  = cue_row_f(CUE_ONE);
						d.rec_ptr   = cue_row_f(CUE_ONE);
						d = blink_f(d, STEP_BLINKS, CUE_ONE, 1'b0, cue_len, S_IDLE);
					end
				end else if (fall.skip && q.cue_mode) begin
					// cue four wraps to cue one through the two-bit index
					d.cue_idx  = q.cue_idx + 2'h1;
					d.play_ptr = cue_row_f(d.cue_idx);
					d.rec_ptr  = cue_row_f(d.cue_idx);
					d = blink_f(d, {2'h0, d.cue_idx} + 4'h1, CUE_ONE, 1'b0, cue_len, S_IDLE);
				end else if (fall.skip && PTR_IS_LAST) begin
					d.play_ptr = FIRST_START_ROW;
					d = blink_f(d, WRAP_BLINKS, CUE_TWO, CUE_PROG[1], cue_len, S_IDLE);
				end else if (fall.skip) begin
					d.play_ptr = NEXT_START_ROW;
					d = blink_f(d, STEP_BLINKS, CUE_ONE, CUE_PROG[0], cue_len, S_IDLE);
				end else if (fall.capture && lvl.skip && q.cue_mode) begin
					d.state   = S_CUE_REC;
					d.rec_on  = 1'b1;
					d.led     = 1'b1;
					d.tmr     = '0;
					d.cue_sel = q.cue_idx;
				end else if (fall.capture && lvl.skip && CUE_PROG[0]) begin
					d = blink_f(d, STEP_BLINKS, CUE_ONE, 1'b1, cue_len, S_REC);
				end else if (fall.capture && lvl.skip) begin
					d.state  = S_REC;
					d.rec_on = 1'b1;
					d.led    = 1'b1;
				end else if (fall.listen && lvl.skip) begin
					d.state    = S_PLAY;
					d.play_on  = 1'b1;
					d.cue_play = q.cue_mode;
					d.cue_sel  = q.cue_idx;
					d.led      = 1'b1;
					d.tmr      = '0;
				end else if (fall.clear && q.cue_mode) begin
					d.cue_clear = 1'b1;
					d.cue_sel   = q.cue_idx;
				end
			end
			// every button edge is dropped here until the last flash ends
			S_BLINK: begin
				d.tmr = q.tmr + 32'h1;
				d.led = q.tmr < (q.per >> 1);
				if (q.tmr >= q.per - 32'h1) begin
					d.tmr    = '0;
					d.led    = 1'b1;
					d.blinks = q.blinks - 4'h1;
					if (q.blinks == STEP_BLINKS) begin
						d.state    = q.ret;
						d.cue_play = 1'b0;
						d.rec_on   = (q.ret == S_REC);
						d.play_on  = (q.ret == S_PLAY);
						d.led      = (q.ret != S_IDLE);
					end
				end
			end
			// only release or full ends a recording; listen and skip edges are dropped
			S_REC: begin
				d.led = 1'b1;
				if (lvl.capture || MEM_FULL) begin
					d.rec_on   = 1'b0;
					d.rec_ptr  = WRITE_ROW;
					d.play_ptr = q.rec_ptr;
					if (CUE_PROG[1]) begin
						d = blink_f(d, WRAP_BLINKS, CUE_TWO, 1'b1, cue_len, S_IDLE);
					end else begin
						d.state = S_IDLE;
						d.led   = 1'b0;
					end
				end
			end
			// cue capture is cut at the rate-dependent length
			S_CUE_REC: begin
				d.tmr = q.tmr + 32'h1;
				if (lvl.capture || MEM_FULL || q.tmr >= cue_len - 32'h1) begin
					d.state  = S_IDLE;
					d.rec_on = 1'b0;
					d.led    = 1'b0;
				end
			end
			// capture and skip edges are dropped here; listen stops, message end may loop
			S_PLAY: begin
				d.tmr = q.tmr + 32'h1;
				if (q.tmr >= LS1_CYC - 32'h1) begin
					d.tmr = '0;
					d.led = ~q.led;
				end
				if (fall.listen || MSG_END) begin
					d.state    = S_IDLE;
					d.play_on  = 1'b0;
					d.cue_play = 1'b0;
					d.led      = 1'b0;
				end
				// a held listen button at message end, outside cue mode, loops on to the next message
				if (MSG_END && !lvl.listen && !fall.listen && !q.cue_mode) begin
					if (PTR_IS_LAST) begin
						d.play_ptr = FIRST_START_ROW;
						d = blink_f(d, WRAP_BLINKS, CUE_TWO, CUE_PROG[1], cue_len, S_PLAY);
					end else begin
						d.play_ptr = NEXT_START_ROW;
						d = blink_f(d, STEP_BLINKS, CUE_ONE, CUE_PROG[0], cue_len, S_PLAY);
					end
				end
			end
			default: begin
				d.state = S_IDLE;
			end
		endcase
	end

	// ==========================================
	// state register; init loads the stored pointers once after reset
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			q       <= '0;
			q.state <= S_IDLE;
			q.ret   <= S_IDLE;
			q.init  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign LED       = q.led;
	assign REC_ON    = q.rec_on;
	assign PLAY_ON   = q.play_on;
	assign CUE_PLAY  = q.cue_play;
	assign CUE_SEL   = q.cue_sel;
	assign CUE_MODE  = q.cue_mode;
	assign CUE_CLEAR = q.cue_clear;
	assign REC_PTR   = q.rec_ptr;
	assign PLAY_PTR  = q.play_ptr;

	// ==========================================
	// checks
	property p_blink_hold;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_BLINK && q.blinks > STEP_BLINKS) |=> (q.state == S_BLINK && !$rose(REC_ON) && !$rose(PLAY_ON));
	endproperty
	a_blink_hold: assert property (p_blink_hold) else $error("button acted during blinking");

	property p_init_empty;
		@(posedge REF_CLK) disable iff (SRST)
		(q.init && STORED_EMPTY) |=> (PLAY_PTR == '0 && REC_PTR == '0);
	endproperty
	a_init_empty: assert property (p_init_empty) else $error("pointers not at start after reset");

	property p_init_stored;
		@(posedge REF_CLK) disable iff (SRST)
		(q.init && !STORED_EMPTY) |=> (PLAY_PTR == $past(STORED_LAST_ROW) && REC_PTR == $past(STORED_FREE_ROW));
	endproperty
	a_init_stored: assert property (p_init_stored) else $error("stored pointers not loaded");

	property p_rec_full;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_REC && MEM_FULL) |=> (!REC_ON && q.state != S_REC);
	endproperty
	a_rec_full: assert property (p_rec_full) else $error("recording went on into full memory");

	property p_rec_ptrs;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_REC && (lvl.capture || MEM_FULL)) |=> (PLAY_PTR == $past(REC_PTR) && REC_PTR == $past(WRITE_ROW));
	endproperty
	a_rec_ptrs: assert property (p_rec_ptrs) else $error("pointers wrong after recording");

	property p_rec_start;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_IDLE && !q.cue_mode && !CMA_BAD && fall.capture && lvl.skip && !CUE_PROG[0])
			|=> (REC_ON && LED) ##1 LED;
	endproperty
	a_rec_start: assert property (p_rec_start) else $error("led not steady at record start");

	property p_corrupt;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_IDLE && !q.cue_mode && CMA_BAD && fall != '0)
			|=> (q.state == S_BLINK && q.blinks == CORRUPT_BLINKS && !REC_ON && !PLAY_ON);
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("corrupt memory not refused");

	property p_skip_wrap;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_IDLE && !q.cue_mode && !CMA_BAD && fall.skip && PTR_IS_LAST)
			|=> (PLAY_PTR == $past(FIRST_START_ROW) && q.blinks == WRAP_BLINKS);
	endproperty
	a_skip_wrap: assert property (p_skip_wrap) else $error("skip from last did not wrap");

	property p_cue_len;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_CUE_REC) |-> (q.tmr < cue_len);
	endproperty
	a_cue_len: assert property (p_cue_len) else $error("cue ran past its length");

	property p_play_stop;
		@(posedge REF_CLK) disable iff (SRST)
		(q.state == S_PLAY && fall.listen) |=> (!PLAY_ON && PLAY_PTR == $past(PLAY_PTR));
	endproperty
	a_play_stop: assert property (p_play_stop) else $error("listen press did not stop playback");

endmodule

// ### design/pbm_pkg.sv
// Overview of operation
// - cue mode: capture, listen, clear act on cue
// - cue mode skip steps cue, blinks its number
// - buttons ignored while the led blinks
// - skip held then capture leaves cue mode
// - cue length limited by sample rate
// - empty memory: both pointers at start
// - stored messages: pointers after and at last
// - capture low records until release or full
// - record end updates both pointers
// - record start: led on, or cue one first
// - record stop: led off, or cue two first
// - corrupt memory: seven blinks, operation refused
// - capture ignored during playback or skip
// - listen pulse plays message, led flashes
// - listen pulse stops playback, pointer kept
// - listen held loops through messages
// - loop without cues: one or two flashes
// - loop with cues: cue one or two between
// - listen ignored during record or skip
// - skip advances pointer, wraps last to first
// - skip not on last: advance, one blink
// - skip on last: pointer to first message
// - wrap shows two blinks or cue two
// - skip held then capture enters cue mode
package pbm_pkg;

	// ==========================================
	// clock and times
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CUE_MS_12K = 330;
	localparam int unsigned CUE_MS_8K  = 500;
	localparam int unsigned CUE_MS_6K4 = 625;
	localparam int unsigned CUE_MS_5K3 = 750;
	localparam int unsigned CUE_MS_4K  = 1000;
	localparam int unsigned DEB_MS     = 10;
	localparam int unsigned LS1_MS     = 250;
	localparam int unsigned LS2_MS     = 150;
	localparam int unsigned HOLD_MS    = 3000;

	// ==========================================
	// memory layout and indication counts
	localparam int unsigned ROW_W          = 11;
	localparam logic [3:0]  CUE_ROWS       = 4'h4;
	localparam logic [3:0]  CORRUPT_BLINKS = 4'h7;
	localparam logic [3:0]  STEP_BLINKS    = 4'h1;
	localparam logic [3:0]  WRAP_BLINKS    = 4'h2;
	localparam logic [1:0]  CUE_ONE        = 2'h0;
	localparam logic [1:0]  CUE_TWO        = 2'h1;
	localparam logic [1:0]  CUE_FOUR       = 2'h3;

	// ==========================================
	// sample rate codes
	localparam logic [2:0] RATE_12K = 3'h0;
	localparam logic [2:0] RATE_8K  = 3'h1;
	localparam logic [2:0] RATE_6K4 = 3'h2;
	localparam logic [2:0] RATE_5K3 = 3'h3;

	// ==========================================
	// types
	typedef struct packed {
		logic capture;
		logic listen;
		logic skip;
		logic clear;
	} pbm_btn_t;

	typedef enum logic [4:0] {
		S_IDLE    = 5'h01,
		S_BLINK   = 5'h02,
		S_REC     = 5'h04,
		S_PLAY    = 5'h08,
		S_CUE_REC = 5'h10
	} pbm_state_t;

	typedef struct packed {
		pbm_state_t       state;
		pbm_state_t       ret;
		logic [3:0]       blinks;
		logic [31:0]      per;
		logic [31:0]      tmr;
		logic [31:0]      hold;
		logic             led;
		logic             rec_on;
		logic             play_on;
		logic             cue_play;
		logic [1:0]       cue_sel;
		logic             cue_mode;
		logic [1:0]       cue_idx;
		logic             cue_clear;
		logic [ROW_W-1:0] play_ptr;
		logic [ROW_W-1:0] rec_ptr;
		logic [ROW_W-1:0] save_play;
		logic [ROW_W-1:0] save_rec;
		logic             init;
	} pbm_st_t;

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        lvl;
		logic        fall;
		logic [31:0] cnt;
	} pbm_deb_t;

endpackage

// ### design/pbm_debounce.sv
`timescale 1ns/1ps
module pbm_debounce
	import pbm_pkg::*;
#(
	parameter logic [31:0] DEB_CYC = 32'h1
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// raw active-low pin
	input  wire logic pin_n,
	// filtered level (high = released) and press pulse
	output logic      level_q,
	output logic      fall_q
);

	pbm_deb_t q;
	pbm_deb_t d;

	// ==========================================
	// filter: level changes only after DEB_CYC stable cycles
	always_comb begin
		d       = q;
		d.sync1 = pin_n;
		d.sync2 = q.sync1;
		d.fall  = 1'b0;
		if (q.sync2 == q.lvl) begin
			d.cnt = '0;
		end else if (q.cnt >= DEB_CYC - 32'h1) begin
			d.cnt  = '0;
			d.lvl  = q.sync2;
			d.fall = ~q.sync2;
		end else begin
			d.cnt = q.cnt + 32'h1;
		end
	end

	// released is the safe level out of reset
	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '{sync1: 1'b1, sync2: 1'b1, lvl: 1'b1, fall: 1'b0, cnt: 32'h0};
		end else begin
			q <= d;
		end
	end

	assign level_q = q.lvl;
	assign fall_q  = q.fall;

endmodule

// ### verif/pbm_btn_model.sv
`timescale 1ns/1ps
// ==========================================
// user push buttons: raw active-low switches with contact bounce
module pbm_btn_model
	import pbm_pkg::*;
(
	// clock used to pace the user
	input  wire logic clk,
	// raw buttons towards the device
	output pbm_btn_t  btn_n
);
	// all released at time zero
	initial btn_n = '1;

	// press with bounce shorter than the filter, hold, then release
	task automatic press(input int b, input int cyc);
		for (int i = 1; i < 5; i++) begin
			@(posedge clk);
			btn_n[b] <= i[0]; // ends low after one glitch
		end
		repeat (cyc) @(posedge clk);
		btn_n[b] <= 1'b1;
		repeat (8) @(posedge clk); // the filter must see the release before a next press
	endtask

	// hold skip well past the hold time, then add capture, release both
	task automatic skip_capture();
		@(posedge clk);
		btn_n.skip <= 1'b0;
		repeat (150) @(posedge clk);
		btn_n.capture <= 1'b0;
		repeat (100) @(posedge clk);
		btn_n.skip    <= 1'b1;
		btn_n.capture <= 1'b1;
		repeat (8) @(posedge clk); // let both releases settle in the filter
	endtask
endmodule

// ### verif/pbm_top_tb.sv
`timescale 1ns/1ps
// ==========================================
// self-checking bench for the message manager
module pbm_top_tb;
	import pbm_pkg::*;

	// skip outcome per pointer position, programmed cues and rate
	typedef struct packed {
		logic       last;
		logic [3:0] prog;
		logic [2:0] rate;
		logic [3:0] n;
		logic [7:0] half;
	} pbm_row_t;

	// high time is half the period plus the cycle in which the flash is launched
	pbm_row_t rows [7] = '{'{1'h0, 4'h0, 3'h0, 4'h1, 8'hb}, '{1'h1, 4'h0, 3'h0, 4'h2, 8'h7},
		'{1'h0, 4'h3, 3'h0, 4'h1, 8'h10}, '{1'h1, 4'h3, 3'h1, 4'h2, 8'h15}, '{1'h0, 4'h3, 3'h2, 4'h1, 8'h1a},
		'{1'h0, 4'h3, 3'h3, 4'h1, 8'h1f}, '{1'h0, 4'h3, 3'h4, 4'h1, 8'h24}};

	// shortened times keep the run short
	localparam logic [31:0] deb_len = 32'h4, fl1_len = 32'h14, fl2_len = 32'hc, hold_len = 32'h64;
	localparam logic [31:0] cue_12k = 32'h1e, cue_8k = 32'h28, cue_6k4 = 32'h32, cue_5k3 = 32'h3c, cue_4k = 32'h46;

	logic        ref_clk  = 1'b0;
	logic        srst     = 1'b1;
	pbm_btn_t    btn_n;
	logic        empty    = 1'b1;
	logic [10:0] wr_row   = 11'h140;
	logic [10:0] free_row = 11'h123;
	logic [10:0] last_row = 11'h100;
	logic [10:0] next_row = 11'h200;
	logic [10:0] first_row = 11'h010;
	logic        is_last  = 1'b0;
	logic        full     = 1'b0;
	logic        msg_end  = 1'b0;
	logic        bad      = 1'b0;
	logic [3:0]  prog     = 4'h0;
	logic [2:0]  rate     = 3'h0;
	logic        led, rec_on, play_on, cue_play, cue_mode, cue_clear;
	logic [1:0]  cue_sel;
	logic [10:0] rec_ptr, play_ptr;
	int          fail_count  = 0;
	int          comparisons = 0;
	int          cycles      = 0;
	int          rises, hi;
	logic        cue_seen, clr_seen, rec_seen;

	// ==========================================
	// clock, device and user
	always #4 ref_clk = ~ref_clk;

	pbm_top #(.DEB_CYC(deb_len), .LS1_CYC(fl1_len), .LS2_CYC(fl2_len), .HOLD_CYC(hold_len),
		.CUE_CYC_12K(cue_12k), .CUE_CYC_8K(cue_8k), .CUE_CYC_6K4(cue_6k4), .CUE_CYC_5K3(cue_5k3),
		.CUE_CYC_4K(cue_4k)) i_dut (.REF_CLK(ref_clk), .SRST(srst), .BUTTON_N(btn_n),
		.STORED_EMPTY(empty), .STORED_FREE_ROW(free_row), .STORED_LAST_ROW(last_row),
		.NEXT_START_ROW(next_row), .FIRST_START_ROW(first_row), .PTR_IS_LAST(is_last),
		.WRITE_ROW(wr_row), .MEM_FULL(full), .MSG_END(msg_end), .CMA_BAD(bad), .CUE_PROG(prog),
		.RATE_SEL(rate), .LED(led), .REC_ON(rec_on), .PLAY_ON(play_on), .CUE_PLAY(cue_play),
		.CUE_SEL(cue_sel), .CUE_MODE(cue_mode), .CUE_CLEAR(cue_clear), .REC_PTR(rec_ptr),
		.PLAY_PTR(play_ptr));

	pbm_btn_model i_btn (.clk(ref_clk), .btn_n(btn_n));

	// ==========================================
	// compare tasks, one per kind of result
	task automatic chk1(input string n, input logic e, input logic s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", n, e, s);
		end
	endtask

	task automatic chkp(input string n, input logic [10:0] e, input logic [10:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chkn(input string n, input int e, input int s);
		comparisons++;
		if (s != e) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", n, e, s);
		end
	endtask

	task automatic conclude();
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// helpers; sampling on the falling edge keeps clear of update races
	task automatic wait_until(input int w, input logic v);
		logic s;
		for (int i = 0; i < 400; i++) begin
			@(negedge ref_clk);
			s = (w == 0) ? rec_on : (w == 1) ? play_on : cue_mode;
			if (s === v)
				return;
		end
		fail_count++;
		$display("Error wait %0d expected %b seen %b", w, v, s);
	endtask

	// count flashes and the high time of the first one over a window
	task automatic watch(input int win);
		logic prev;
		prev = 1'b0; // a flash already lit at the start counts as one
		{rises, hi, cue_seen, clr_seen, rec_seen} = '0;
		repeat (win) begin
			@(negedge ref_clk);
			if (led === 1'b1 && prev !== 1'b1)
				rises++;
			if (led === 1'b1 && rises == 1)
				hi++;
			cue_seen |= (cue_play === 1'b1);
			clr_seen |= (cue_clear === 1'b1);
			rec_seen |= (rec_on === 1'b1);
			prev = led;
		end
	endtask

	task automatic pulse_end();
		@(posedge ref_clk);
		msg_end <= 1'b1;
		@(posedge ref_clk);
		msg_end <= 1'b0;
	endtask

	task automatic do_reset(input logic e);
		@(posedge ref_clk);
		srst  <= 1'b1;
		empty <= e;
		repeat (10) @(posedge ref_clk);
		srst <= 1'b0;
		@(negedge ref_clk);
		chk1("led in reset", 1'b0, led);
		repeat (3) @(negedge ref_clk);
	endtask

	// hang guard: the whole sequence needs well under this many cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("Error timeout after %0d cycles", cycles);
			conclude();
		end
	end

	// ==========================================
	// main sequence
	initial begin
		do_reset(1'b1);
		chkp("rec_ptr empty", 11'h000, rec_ptr);
		chkp("play_ptr empty", 11'h000, play_ptr);
		do_reset(1'b0);
		chkp("rec_ptr stored", 11'h123, rec_ptr);
		chkp("play_ptr stored", 11'h100, play_ptr);
		// record ended by release, no cues
		fork i_btn.press(3, 60); join_none
		wait_until(0, 1'b1);
		chk1("led at record", 1'b1, led);
		wait_until(0, 1'b0);
		chkp("rec_ptr after", 11'h140, rec_ptr);
		chkp("play_ptr after", 11'h123, play_ptr);
		chk1("led at stop", 1'b0, led);
		// record ended by full memory with cue two programmed
		@(posedge ref_clk);
		wr_row <= 11'h150;
		prog   <= 4'h2;
		fork i_btn.press(3, 200); join_none
		wait_until(0, 1'b1);
		@(posedge ref_clk);
		full <= 1'b1;
		wait_until(0, 1'b0);
		chk1("cue at stop", 1'b1, cue_play);
		chkp("rec_ptr full", 11'h150, rec_ptr);
		watch(250);
		chkn("stop flashes", 2, rises);
		@(posedge ref_clk);
		full <= 1'b0;
		prog <= 4'h0;
		// listen, capture ignored, listen stops, then natural end
		i_btn.press(2, 8);
		wait_until(1, 1'b1);
		i_btn.press(3, 8);
		@(negedge ref_clk);
		chk1("rec during play", 1'b0, rec_on);
		i_btn.press(2, 8);
		wait_until(1, 1'b0);
		chkp("play_ptr stop", 11'h140, play_ptr);
		i_btn.press(2, 8);
		wait_until(1, 1'b1);
		chk1("led in play", 1'b1, led);
		pulse_end();
		wait_until(1, 1'b0);
		chk1("led after play", 1'b0, led);
		chkp("play_ptr end", 11'h140, play_ptr);
		// listen pressed while the skip flash runs
		fork
			i_btn.press(1, 8);
			begin
				repeat (12) @(posedge ref_clk);
				i_btn.press(2, 8);
			end
		join
		repeat (4) @(negedge ref_clk);
		chk1("play during blink", 1'b0, play_on);
		chkp("play_ptr skip", 11'h200, play_ptr);
		repeat (20) @(negedge ref_clk);
		// table of skip presses
		foreach (rows[r]) begin
			@(posedge ref_clk);
			is_last <= rows[r].last;
			prog    <= rows[r].prog;
			rate    <= rows[r].rate;
			next_row <= next_row + 11'h8;
			fork i_btn.press(1, 8); watch(120); join
			chkn("skip flashes", rows[r].n, rises);
			chkn("half period", rows[r].half, hi);
			chk1("cue with skip", rows[r].prog != 4'h0, cue_seen);
			chkp("play_ptr row", rows[r].last ? first_row : next_row, play_ptr);
		end
		// looped playback from the last message
		@(posedge ref_clk);
		prog    <= 4'h0;
		is_last <= 1'b1;
		fork
			i_btn.press(2, 150);
			begin
				wait_until(1, 1'b1);
				repeat (5) @(posedge ref_clk);
				pulse_end();
				repeat (3) @(negedge ref_clk);
				chkp("play_ptr loop", 11'h010, play_ptr);
			end
		join
		repeat (10) @(posedge ref_clk);
		pulse_end();
		wait_until(1, 1'b0);
		chkp("play_ptr loop end", 11'h010, play_ptr);
		// cue editing: enter, step, clear, leave
		i_btn.skip_capture();
		wait_until(2, 1'b1);
		chkp("play_ptr cue", 11'h000, play_ptr);
		fork i_btn.press(1, 8); watch(80); join
		chkn("cue flashes", 2, rises);
		chkp("play_ptr cue two", 11'h004, play_ptr);
		fork i_btn.press(0, 8); watch(30); join
		chk1("cue clear", 1'b1, clr_seen);
		// cue capture held past the cue length is cut while the button is still down
		fork
			i_btn.press(3, 100);
			begin
				wait_until(0, 1'b1);
				chkp("cue_sel rec", 11'h001, 11'(cue_sel));
				repeat (80) @(negedge ref_clk);
				chk1("cue rec cut", 1'b0, rec_on);
			end
		join
		i_btn.skip_capture();
		wait_until(2, 1'b0);
		repeat (50) @(negedge ref_clk);
		chkp("play_ptr restored", 11'h010, play_ptr);
		chkp("rec_ptr restored", 11'h150, rec_ptr);
		// corrupt memory refuses a record
		@(posedge ref_clk);
		bad <= 1'b1;
		fork i_btn.press(3, 8); watch(200); join
		chkn("corrupt flashes", 7, rises);
		chk1("rec refused", 1'b0, rec_seen);
		conclude();
	end
endmodule
